// ### one_wire_pkg.sv
// constants and types for the one-wire bus master
`default_nettype none

package one_wire_pkg;

  // ****************************************************************
  // clock and time base
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US = 1000;
  localparam int US_CYCLES = NS_PER_US / CLK_PERIOD_NS;
  localparam int PRE_W = 7;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(US_CYCLES - 1);
  localparam logic [PRE_W-1:0] PRE_ZERO = 7'h00;

  // ****************************************************************
  // line timing, in microseconds
  // ****************************************************************
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
  localparam logic [CNT_W-1:0] RSTL_US = 10'd511;
  localparam logic [CNT_W-1:0] RSTH_US = 10'd512;
  localparam logic [CNT_W-1:0] WR0_LOW_US = 10'd100;
  localparam logic [CNT_W-1:0] LOW1_US = 10'd5;
  localparam logic [CNT_W-1:0] SLOT_US = 10'd117;
  localparam logic [CNT_W-1:0] READ_SAMPLE_US = 10'd13;
  localparam logic [CNT_W-1:0] PD_SETTLE_US = 10'd2;

  // ****************************************************************
  // fifo shape
  // ****************************************************************
  localparam int FIFO_DEPTH = 4;

  // ****************************************************************
  // command and answer words
  // ****************************************************************
  typedef enum logic [1:0] {
    OP_RESET = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ = 2'h2
  } op_e;

  typedef struct packed {
    op_e op;
    logic wbit;
  } cmd_s;

  typedef struct packed {
    logic is_reset;
    logic rbit;
    logic absent;
  } rsp_s;

  localparam int RSP_W = $bits(rsp_s);

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RST_LOW = 6'h02,
    ST_RST_HIGH = 6'h04,
    ST_SLOT_LOW = 6'h08,
    ST_SLOT_REL = 6'h10,
    ST_PUSH = 6'h20
  } state_e;

endpackage : one_wire_pkg

`default_nettype wire

// ### ow_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none

module ow_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  // ****************************************************************
  // pointers and fill level
  // ****************************************************************
  // honest flags straight from the count; no bypass, so a full
  // fifo refuses even when popping in the same cycle
  assign in_ready = (cnt_q != FULL_CNT);
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == LAST_IDX) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == LAST_IDX) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // ****************************************************************
  // storage
  // ****************************************************************
  // one register per entry, written only at its own index
  for (genvar i = 0; i < DEPTH; i++) begin : g_mem
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        mem_q[i] <= '0;
      end else if (push && wr_q == AW'(i)) begin
        mem_q[i] <= in_data;
      end
    end
  end

endmodule : ow_fifo

`default_nettype wire

// ### one_wire_master.sv
// one-wire bus master: reset/presence, write and read time slots
`timescale 1ns/1ns
`default_nettype none

module one_wire_master #(
  parameter logic [9:0] RSTL_TIME_US = 10'd511,
  parameter logic [9:0] RSTH_TIME_US = 10'd512
) (
  input wire logic mclk,
  input wire logic rst,
  // command side
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire one_wire_pkg::cmd_s cmd,
  // answer side, through the fifo
  output logic rsp_valid,
  input wire logic rsp_ready,
  output one_wire_pkg::rsp_s rsp,
  // status
  output logic busy,
  output logic absent,
  // open-drain line
  input wire logic owire_in,
  output logic owire_out,
  output logic owire_oe
);

  import one_wire_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  state_e state_q, state_d;
  logic [PRE_W-1:0] pre_q, pre_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  cmd_s cur_q, cur_d;
  logic seen_q, seen_d;
  logic rbit_q, rbit_d;
  logic absent_q, absent_d;
  logic oe_q, oe_d;
  logic tick;
  logic restart;
  logic fifo_in_ready;
  logic fifo_in_valid;
  rsp_s fifo_in;
  logic [CNT_W-1:0] low_len;

  // true on the tick that closes microsecond number lim
  function automatic logic phase_end(
    input logic [CNT_W-1:0] cnt,
    input logic t,
    input logic [CNT_W-1:0] lim
  );
    phase_end = t && (cnt == lim - CNT_ONE);
  endfunction : phase_end

  // ****************************************************************
  // microsecond time base
  // ****************************************************************
  // the prescaler restarts with every command, and each phase ends on a tick, so each phase lasts
  // whole microseconds from its first cycle, not from a free tick
  assign tick = (pre_q == PRE_LAST);

  always_comb begin
    if (restart || tick) begin
      pre_d = PRE_ZERO;
    end else begin
      pre_d = pre_q + 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pre_q <= PRE_ZERO;
    end else begin
      pre_q <= pre_d;
    end
  end

  // ****************************************************************
  // low time of the current slot
  // ****************************************************************
  always_comb begin
    if (cur_q.op == OP_WRITE && !cur_q.wbit) begin
      low_len = WR0_LOW_US;
    end else begin
      low_len = LOW1_US;
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // one command at a time; cmd_ready only in idle, so a full
  // answer fifo holds the sequencer in push and stalls the source
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    cur_d = cur_q;
    seen_d = seen_q;
    rbit_d = rbit_q;
    absent_d = absent_q;
    oe_d = oe_q;
    restart = 1'b0;
    if (tick) begin
      cnt_d = cnt_q + CNT_ONE;
    end
    unique case (state_q)
      ST_IDLE: begin
        oe_d = 1'b0;
        cnt_d = CNT_ZERO;
        if (cmd_valid) begin
          cur_d = cmd;
          restart = 1'b1;
          oe_d = 1'b1;
          if (cmd.op == OP_RESET) begin
            state_d = ST_RST_LOW;
          end else begin
            state_d = ST_SLOT_LOW;
          end
        end
      end
      ST_RST_LOW: begin
        // line held low for the whole reset time
        if (phase_end(cnt_q, tick, RSTL_TIME_US)) begin
          state_d = ST_RST_HIGH;
          cnt_d = CNT_ZERO;
          oe_d = 1'b0;
          seen_d = 1'b0;
        end
      end
      ST_RST_HIGH: begin
        // skip the first microseconds while the pull-up recovers,
        // then any low level counts as a presence answer
        if (cnt_q >= PD_SETTLE_US && !owire_in) begin
          seen_d = 1'b1;
        end
        if (phase_end(cnt_q, tick, RSTH_TIME_US)) begin
          state_d = ST_PUSH;
          absent_d = !seen_d;
        end
      end
      ST_SLOT_LOW: begin
        // counter keeps running into the release phase so the
        // slot length covers low and release together
        if (phase_end(cnt_q, tick, low_len)) begin
          state_d = ST_SLOT_REL;
          oe_d = 1'b0;
        end
      end
      ST_SLOT_REL: begin
        if (cur_q.op == OP_READ &&
            phase_end(cnt_q, tick, READ_SAMPLE_US)) begin
          rbit_d = owire_in;
        end
        if (phase_end(cnt_q, tick, SLOT_US)) begin
          if (cur_q.op == OP_READ) begin
            state_d = ST_PUSH;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_PUSH: begin
        oe_d = 1'b0;
        if (fifo_in_ready) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        oe_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= CNT_ZERO;
      cur_q <= '0;
      seen_q <= 1'b0;
      rbit_q <= 1'b0;
      absent_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      cur_q <= cur_d;
      seen_q <= seen_d;
      rbit_q <= rbit_d;
      absent_q <= absent_d;
      oe_q <= oe_d;
    end
  end

  // ****************************************************************
  // answer path
  // ****************************************************************
  // reads and resets leave one word each; writes leave none
  assign fifo_in_valid = (state_q == ST_PUSH);
  assign fifo_in.is_reset = (cur_q.op == OP_RESET);
  assign fifo_in.rbit = (cur_q.op == OP_READ) ? rbit_q : 1'b0;
  assign fifo_in.absent = (cur_q.op == OP_RESET) ? absent_q : 1'b0;

  ow_fifo #(
    .WIDTH(RSP_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(rsp_valid),
    .out_ready(rsp_ready),
    .out_data(rsp)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  // open drain: only ever pull low, release by dropping the enable
  assign owire_out = 1'b0;
  assign owire_oe = oe_q;
  assign cmd_ready = (state_q == ST_IDLE);
  assign busy = (state_q != ST_IDLE);
  assign absent = absent_q;

endmodule : one_wire_master

`default_nettype wire

// ### ow_master_chk_sva.sv
// checker for the one-wire master line timing and answers
`timescale 1ns/1ns
`default_nettype none
module ow_master_chk #(
  parameter logic [9:0] RSTL_TIME_US = 10'h1FF,
  parameter logic [9:0] RSTH_TIME_US = 10'h200
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire one_wire_pkg::cmd_s cmd,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire one_wire_pkg::rsp_s rsp,
  input wire logic busy,
  input wire logic absent,
  input wire logic owire_in,
  input wire logic owire_out,
  input wire logic owire_oe
);
  import one_wire_pkg::*;
  localparam int RL = RSTL_TIME_US * 100;
  localparam int RH = RSTH_TIME_US * 100;
  cmd_s cmd_q, cmd_d;
  logic [16:0] low_q, low_d, bsy_q, bsy_d;
  logic seen_q, seen_d, smp_q, smp_d;
  // last command, low and busy run lengths, line seen low, read sample
  always_comb begin
    cmd_d = (cmd_valid && cmd_ready) ? cmd : cmd_q;
    low_d = owire_oe ? low_q + 17'h00001 : 17'h00000;
    bsy_d = busy ? bsy_q + 17'h00001 : 17'h00000;
    seen_d = (cmd_valid && cmd_ready) ? 1'b0 :
             (seen_q | (busy & ~owire_oe & ~owire_in));
    smp_d = (bsy_q == 17'h003E8) ? owire_in : smp_q;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_q <= '0;
      low_q <= '0;
      bsy_q <= '0;
      seen_q <= 1'b0;
      smp_q <= 1'b0;
    end else begin
      cmd_q <= cmd_d;
      low_q <= low_d;
      bsy_q <= bsy_d;
      seen_q <= seen_d;
      smp_q <= smp_d;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_fall(op_e o);
    $fell(owire_oe) && cmd_q.op == o;
  endsequence
  // write-zero and short-low releases, qualified inside the sequence
  sequence s_fall_wr0;
    $fell(owire_oe) && cmd_q.op == OP_WRITE && !cmd_q.wbit;
  endsequence
  sequence s_fall_short;
    $fell(owire_oe) &&
    (cmd_q.op == OP_READ || (cmd_q.op == OP_WRITE && cmd_q.wbit));
  endsequence
  sequence s_end(op_e o);
    $rose(cmd_ready) && cmd_q.op == o;
  endsequence
  a_take_pulls_low: assert property (s_take |=> owire_oe && !cmd_ready)
    else $error("line not pulled after command");
  a_wr0_low_time: assert property (s_fall_wr0 |-> low_q == 17'h02710)
    else $error("write zero low time wrong");
  a_short_low_time: assert property (s_fall_short |-> low_q == 17'h001F4)
    else $error("short low time wrong");
  a_reset_low_time: assert property (s_fall(OP_RESET) |-> low_q == RL)
    else $error("reset low time wrong");
  a_slot_length: assert property ($rose(cmd_ready) && cmd_q.op != OP_RESET |-> bsy_q >= 17'h02DB4 && bsy_q <= 17'h02EE0)
    else $error("slot length out of range");
  a_release_time: assert property (s_end(OP_RESET) |-> bsy_q >= RL + RH)
    else $error("reset release too short");
  a_absent_flag: assert property (s_end(OP_RESET) |-> absent == !seen_q)
    else $error("absent flag wrong");
  a_read_bit: assert property ($rose(rsp_valid) && cmd_q.op == OP_READ |-> rsp.rbit == smp_q)
    else $error("read bit differs from line");
  a_answer_holds: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
    else $error("answer changed before pop");
endmodule : ow_master_chk
bind one_wire_master ow_master_chk #(.RSTL_TIME_US(RSTL_TIME_US),
  .RSTH_TIME_US(RSTH_TIME_US)) u_chk (.mclk(mclk), .rst(rst),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
  .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp), .busy(busy),
  .absent(absent), .owire_in(owire_in), .owire_out(owire_out),
  .owire_oe(owire_oe));
`default_nettype wire

// ### ow_slave_model.sv
// behavioural one-wire slave: presence and read-zero answers
`timescale 1ns/1ns
`default_nettype none
module ow_slave_model #(
  parameter int RST_US = 10,
  parameter int PDH_US = 15,
  parameter int PDL_US = 60
) (
  input wire logic line,
  input wire logic present,
  input wire logic rd_zero,
  output logic pull
);
  realtime fall_t;
  initial pull = 1'b0;
  // read zero: hold low well past the master's sample point
  always @(negedge line) begin
    fall_t = $realtime;
    if (rd_zero && !pull) begin
      pull = 1'b1;
      #30000 pull = 1'b0;
    end
  end
  // only a low of reset length earns a presence answer
  always @(posedge line) begin
    if (present && $realtime - fall_t > (RST_US - 1) * 1000.0 &&
        $realtime - fall_t < (RST_US + 1) * 1000.0) begin
      #(PDH_US * 1000) pull = 1'b1;
      #(PDL_US * 1000) pull = 1'b0;
    end
  end
endmodule : ow_slave_model
`default_nettype wire

// ### tb_one_wire_master.sv
// self-checking bench for the one-wire bus master
`timescale 1ns/1ns
`default_nettype none
module tb_one_wire_master;
  import one_wire_pkg::*;
  // short reset counts keep the run brief
  localparam logic [9:0] RSTL = 10'h00A;
  localparam logic [9:0] RSTH = 10'h01E;
  localparam int RL = RSTL * 100;
  localparam int RH = RSTH * 100;
  logic mclk, rst, cmd_valid, cmd_ready, rsp_valid, rsp_ready, busy;
  logic absent, owire_out, owire_oe, line, pull, present, rd_zero;
  cmd_s cmd;
  rsp_s rsp;
  int failures, tests_run;
  logic [16:0] low_n, slot_n;
  one_wire_master #(.RSTL_TIME_US(RSTL), .RSTH_TIME_US(RSTH)) DUT (
    .mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp),
    .busy(busy), .absent(absent), .owire_in(line),
    .owire_out(owire_out), .owire_oe(owire_oe));
  ow_slave_model #(.RST_US(RL / 100)) u_slave (.line(line),
    .present(present), .rd_zero(rd_zero), .pull(pull));
  // open-drain line, pulled up when nobody drives
  assign line = ~((owire_oe & ~owire_out) | pull);
  always #5 mclk = ~mclk;
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic chk(string w, logic [16:0] e, logic [16:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", w, e, g);
    end
  endtask : chk
  // wait for an idle master and a high line; bounded
  task automatic wait_idle();
    int n;
    n = 0;
    while ((cmd_ready !== 1'b1 || line !== 1'b1) && n < 20000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 20000) chk("idle wait", 17'h00000, 17'h00001);
  endtask : wait_idle
  // one command; counts low cycles and busy cycles until ready again
  task automatic send(op_e op, logic wb);
    int n;
    wait_idle();
    cmd = '{op: op, wbit: wb};
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
    low_n = '0;
    slot_n = '0;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 20000) begin
      low_n += {16'h0000, owire_oe};
      slot_n++;
      n++;
      @(negedge mclk);
    end
    if (n >= 20000) chk("command end", 17'h00000, 17'h00001);
  endtask : send
  task automatic pop(rsp_s e);
    int n;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    chk("answer word", {14'h0000, e}, {14'h0000, rsp});
    rsp_ready = 1'b1;
    @(negedge mclk);
    rsp_ready = 1'b0;
  endtask : pop
  task automatic slot_ok();
    chk("slot range", 17'h00001,
        {16'h0000, slot_n >= 17'h02DB4 && slot_n <= 17'h02EE0});
  endtask : slot_ok
  task automatic t_reset(logic pres);
    present = pres;
    send(OP_RESET, 1'b0);
    chk("reset low", 17'(RL), low_n);
    chk("reset span", 17'h00001, {16'h0000, slot_n >= 17'(RL + RH)});
    chk("absent port", {16'h0000, !pres}, {16'h0000, absent});
    pop('{is_reset: 1'b1, rbit: 1'b0, absent: !pres});
    $display("test reset presence=%0d done", pres);
  endtask : t_reset
  task automatic t_writes();
    send(OP_WRITE, 1'b0);
    chk("write zero low", 17'h02710, low_n);
    slot_ok();
    send(OP_WRITE, 1'b1);
    chk("write one low", 17'h001F4, low_n);
    slot_ok();
    chk("no answer", 17'h00000, {16'h0000, rsp_valid});
    $display("test writes done");
  endtask : t_writes
  task automatic t_read(logic b);
    rd_zero = !b;
    send(OP_READ, 1'b0);
    chk("read low", 17'h001F4, low_n);
    slot_ok();
    pop('{is_reset: 1'b0, rbit: b, absent: 1'b0});
    $display("test read %0d done", b);
  endtask : t_read
  // four answers fill the fifo; a fifth reset must wait for a pop
  // no slave answers here, so no presence tail stretches the run
  task automatic t_fifo_full();
    present = 1'b0;
    repeat (4) send(OP_RESET, 1'b0);
    wait_idle();
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
    repeat (RL + RH + 300) @(negedge mclk);
    chk("held while full", 17'h00000, {16'h0000, cmd_ready});
    rsp_ready = 1'b1;
    repeat (4) begin
      chk("drained word", 17'h00005, {14'h0000, rsp});
      @(negedge mclk);
    end
    rsp_ready = 1'b0;
    @(negedge mclk);
    pop('{is_reset: 1'b1, rbit: 1'b0, absent: 1'b1});
    wait_idle();
    chk("ready after drain", 17'h00001, {16'h0000, cmd_ready});
    $display("test fifo full done");
  endtask : t_fifo_full
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    rsp_ready = 1'b0;
    present = 1'b1;
    rd_zero = 1'b0;
    failures = 0;
    tests_run = 0;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    t_reset(1'b1);
    t_reset(1'b0);
    t_writes();
    t_read(1'b0);
    t_read(1'b1);
    t_fifo_full();
    test_done();
  end
  // hang guard, well past the expected run length
  initial begin
    #950000;
    failures++;
    test_done();
  end
endmodule : tb_one_wire_master
`default_nettype wire
